/* File: core/ccs_store.sv */
/*
  Common command interpreter with a twenty-slot setting store, service request
  mask and status byte. Assumes commands come from bus logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: Recall slot 0..19 makes that slot the active setting.
// R2: Recalling slot zero loads the standard setting.
// R3: Slots 1..19 return exactly what save stored.
// R4: Reset copies standard setting to active and cancels pending completion.
// R5: After reset the device goes idle awaiting a command.
// R6: Reset empties the key queue.
// R7: Reset leaves bus state, address, output queue and both masks.
// R8: Standard trigger: input off, free run, positive slope, 0V, count 1, 1ms.
// R9: Per-channel fields; levels +0.5V/-0.5V, limit, invert, outputs off.
// R10: Save writes active setting to slots 1..19; slot zero read-only.
// R11: Saved setting covers exactly the standard setting scope.
// R12: Writing mask value 0..255 enables matching status byte bits.
// R13: Mask cleared at power-on or write of zero only.
// R14: Status bits 6,5,4,0 used; bits 7,3,2,1 read zero.
// R15: Mask query returns current mask contents.
// R16: Status byte query returns contents unchanged.
// R17: Trigger fires pulse in triggered mode, burst in burst mode.
// R18: Trigger turns external trigger input enable off.
// R19: Self-test returns result 0..657 to output queue, zero means pass.
// R20: Command and key entries refused while self-test runs.
// R21: Setting active at self-test start restored when it finishes.
// R22: Wait blocks further commands for two seconds.
// R23: Masked event status forms status byte bit 5.
// R24: Master summary set when enabled non-bit-6 status bit set.
// R25: Out-of-range recall or save changes nothing and flags execution error.
module ccs_store #(
  parameter longint WAIT_CYCLES = ccs_pkg::WAIT_CYCLES,
  parameter int SELFTEST_CYCLES = ccs_pkg::SELFTEST_CYCLES
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [3:0] CMD_CODE_IN,
  input wire logic [7:0] CMD_ARG_IN,
  output logic CMD_READY_OUT,
  input wire logic KEY_VALID_IN,
  output logic KEY_READY_OUT,
  output logic KEY_QUEUE_FLUSH_OUT,
  output logic OPC_CANCEL_OUT,
  output logic EXEC_ERROR_OUT,
  input wire logic [7:0] EVENT_STATUS_IN,
  input wire logic [7:0] EVENT_ENABLE_IN,
  input wire logic MSG_AVAIL_IN,
  input wire logic DEVICE_SUMMARY_IN,
  output logic RESP_VALID_OUT,
  output logic [9:0] RESP_DATA_OUT,
  input wire logic [9:0] SELFTEST_RESULT_IN,
  output logic SELFTEST_BUSY_OUT,
  output logic TRIGGER_FIRE_OUT,
  output logic BURST_FIRE_OUT,
  output logic [ccs_pkg::SET_W-1:0] ACTIVE_SETTING_OUT,
  input wire logic SETTING_WE_IN,
  input wire logic [ccs_pkg::SET_W-1:0] SETTING_IN
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_TEST
  } ccs_state_type;

  // The cycle counter is 32 bits wide, so longer waits cannot be served.
  generate
    if (WAIT_CYCLES < 1 || WAIT_CYCLES > longint'(32'hffff_ffff)) begin : gen_bad_wait
      $error("Wait count must lie between one and the counter range.");
    end
    if (SELFTEST_CYCLES < 1) begin : gen_bad_test
      $error("Self-test count must be at least one cycle.");
    end
  endgenerate

  // Command decode, gated by acceptance in the idle state.
  function automatic logic cmd_taken(input logic taken, input logic [3:0] code,
                                     input logic [3:0] want);
    cmd_taken = taken && code == want;
  endfunction

  ccs_state_type state_reg;
  ccs_state_type state_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [ccs_pkg::SET_W-1:0] slots_reg [1:ccs_pkg::NUM_SLOTS-1];
  logic [ccs_pkg::SET_W-1:0] active_reg;
  logic [ccs_pkg::SET_W-1:0] active_next;
  logic [ccs_pkg::SET_W-1:0] saved_reg;
  logic [7:0] mask_reg;
  logic [9:0] resp_reg;
  logic resp_valid_reg;
  logic err_reg;
  logic trig_reg;
  logic burst_reg;
  logic flush_reg;
  logic cancel_reg;

  wire logic take;
  wire logic is_rcl;
  wire logic is_sav;
  wire logic is_rst;
  wire logic is_mask_set;
  wire logic is_mask_q;
  wire logic is_status_q;
  wire logic is_trg;
  wire logic is_tst;
  wire logic is_wai;
  wire logic rcl_ok;
  wire logic sav_ok;
  wire logic rcl_bad;
  wire logic sav_bad;
  wire logic [4:0] slot_idx;
  wire logic [2:0] act_mode;
  wire logic test_done;
  wire logic load_ok;
  wire logic fire_trig;
  wire logic fire_burst;
  wire logic event_summary;
  wire logic [7:0] status_low;
  wire logic master_summary;
  wire logic [7:0] status_byte;

  assign take = CMD_VALID_IN && state_reg == ST_IDLE;
  assign is_rcl = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_RCL);
  assign is_sav = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_SAV);
  assign is_rst = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_RST);
  assign is_mask_set = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_MASK_SET);
  assign is_mask_q = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_MASK_QUERY);
  assign is_status_q = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_STATUS_QUERY);
  assign is_trg = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_TRG);
  assign is_tst = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_TSTQ);
  assign is_wai = cmd_taken(take, CMD_CODE_IN, ccs_pkg::CMD_WAI);
  assign rcl_ok = CMD_ARG_IN < 8'(ccs_pkg::NUM_SLOTS); // [R1]
  assign sav_ok = CMD_ARG_IN != 8'h00 && rcl_ok; // [R10]
  assign rcl_bad = is_rcl && !rcl_ok; // [R25]
  assign sav_bad = is_sav && !sav_ok; // [R25]
  assign slot_idx = CMD_ARG_IN[4:0];
  assign act_mode = active_reg[ccs_pkg::SET_MODE_LSB +: 3];
  assign test_done = state_reg == ST_TEST && count_reg == 32'h0;
  // Setting loads are held off while the self-test owns the setting.
  assign load_ok = SETTING_WE_IN && state_reg != ST_TEST; // [R20]
  assign fire_trig = is_trg && act_mode == ccs_pkg::MODE_TRIG; // [R17]
  assign fire_burst = is_trg && act_mode == ccs_pkg::MODE_BURST; // [R17]

  // Status byte: unused bits are constant zero. [R14]
  assign event_summary = |(EVENT_STATUS_IN & EVENT_ENABLE_IN); // [R23]
  assign status_low = {2'b00, event_summary, MSG_AVAIL_IN, 3'b000, DEVICE_SUMMARY_IN};
  assign master_summary = |(status_low & mask_reg & 8'hbf); // [R24]
  assign status_byte = status_low | {1'b0, master_summary, 6'h00};

  assign CMD_READY_OUT = state_reg == ST_IDLE; // [R20] [R22]
  assign KEY_READY_OUT = state_reg != ST_TEST; // [R20]
  assign SELFTEST_BUSY_OUT = state_reg == ST_TEST;
  assign ACTIVE_SETTING_OUT = active_reg;
  assign RESP_DATA_OUT = resp_reg;
  assign RESP_VALID_OUT = resp_valid_reg;
  assign EXEC_ERROR_OUT = err_reg;
  assign TRIGGER_FIRE_OUT = trig_reg;
  assign BURST_FIRE_OUT = burst_reg;
  assign KEY_QUEUE_FLUSH_OUT = flush_reg;
  assign OPC_CANCEL_OUT = cancel_reg;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    if (count_reg != 32'h0) begin
      count_next = count_reg - 32'h1;
    end
    active_next = active_reg;
    if (load_ok) begin
      active_next = SETTING_IN;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (is_rcl && rcl_ok) begin
          active_next = (slot_idx == 5'h00) ? ccs_pkg::STD_SETTING // [R2]
                                            : slots_reg[slot_idx]; // [R1] [R3]
        end
        if (is_rst) begin
          active_next = ccs_pkg::STD_SETTING; // [R4] [R8] [R9]
          state_next = ST_IDLE; // [R5]
        end
        if (is_trg) begin
          active_next[ccs_pkg::SET_TRIG_STATE_BIT] = 1'b0; // [R18]
        end
        if (is_wai) begin
          state_next = ST_WAIT; // [R22]
          count_next = 32'(WAIT_CYCLES - 1);
        end
        if (is_tst) begin
          state_next = ST_TEST; // [R20]
          count_next = 32'(SELFTEST_CYCLES - 1);
        end
      end
      ST_WAIT: begin
        if (count_reg == 32'h0) begin
          state_next = ST_IDLE;
        end
      end
      ST_TEST: begin
        if (count_reg == 32'h0) begin
          state_next = ST_IDLE;
          active_next = saved_reg; // [R21]
        end
      end
      default: begin
        // A stray state code falls back to idle rather than locking the bus.
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg <= ST_IDLE;
      count_reg <= 32'h0;
      active_reg <= ccs_pkg::STD_SETTING;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      active_reg <= active_next;
    end
  end

  // The copy comes from the register, so a load in the query's own cycle
  // is dropped when the test ends.
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      saved_reg <= ccs_pkg::STD_SETTING;
    end else if (is_tst) begin
      saved_reg <= active_reg; // [R21]
    end
  end

  // Only power-on and a mask write touch the mask; the reset command does not.
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      mask_reg <= ccs_pkg::MASK_RESET; // [R13]
    end else if (is_mask_set) begin
      mask_reg <= CMD_ARG_IN; // [R12] [R7]
    end
  end

  // Slots hold full settings, same width as the standard one. [R11]
  genvar g;
  generate
    for (g = 1; g < ccs_pkg::NUM_SLOTS; g++) begin : gen_slot
      always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          slots_reg[g] <= ccs_pkg::STD_SETTING;
        end else if (is_sav && sav_ok && slot_idx == 5'(g)) begin
          slots_reg[g] <= active_reg; // [R10]
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      resp_reg <= 10'h000;
      resp_valid_reg <= 1'b0;
    end else begin
      resp_valid_reg <= is_mask_q || is_status_q || test_done;
      if (is_mask_q) begin
        resp_reg <= {2'b00, mask_reg}; // [R15]
      end else if (is_status_q) begin
        resp_reg <= {2'b00, status_byte}; // [R16]
      end else if (test_done) begin
        resp_reg <= SELFTEST_RESULT_IN; // [R19]
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= rcl_bad || sav_bad; // [R25]
    end
  end

  // Fire pulses follow the mode held before the same command clears the input enable.
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      trig_reg <= 1'b0;
      burst_reg <= 1'b0;
    end else begin
      trig_reg <= fire_trig; // [R17]
      burst_reg <= fire_burst; // [R17]
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      flush_reg <= 1'b0;
      cancel_reg <= 1'b0;
    end else begin
      flush_reg <= is_rst; // [R6]
      cancel_reg <= is_rst; // [R4]
    end
  end
endmodule // ccs_store
`default_nettype wire

/* File: core/ccs_pkg.sv */
/*
  Constants for the common command and status store: command codes, status
  byte layout, standard setting field values and timing counts.
  Assumes a 250 MHz core clock.
*/
package ccs_pkg;
  localparam int CLK_MHZ = 250;
  localparam int WAIT_TIME_MS = 2000;
  localparam longint WAIT_CYCLES = longint'(WAIT_TIME_MS) * 1000 * CLK_MHZ;
  localparam int SELFTEST_TIME_US = 100;
  localparam int SELFTEST_CYCLES = SELFTEST_TIME_US * CLK_MHZ;
  localparam int NUM_SLOTS = 20;
  localparam int SET_W = 128;
  localparam logic [3:0] CMD_RCL = 4'h1;
  localparam logic [3:0] CMD_SAV = 4'h2;
  localparam logic [3:0] CMD_RST = 4'h3;
  localparam logic [3:0] CMD_MASK_SET = 4'h4;
  localparam logic [3:0] CMD_MASK_QUERY = 4'h5;
  localparam logic [3:0] CMD_STATUS_QUERY = 4'h6;
  localparam logic [3:0] CMD_TRG = 4'h7;
  localparam logic [3:0] CMD_TSTQ = 4'h8;
  localparam logic [3:0] CMD_WAI = 4'h9;
  localparam int STATUS_MSS_BIT = 6;
  localparam int STATUS_ESB_BIT = 5;
  localparam int STATUS_MAV_BIT = 4;
  localparam int STATUS_DEV_BIT = 0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Setting layout: trigger block in [31:0], channel 1 [79:32], channel 2 [127:80].
  localparam int SET_TRIG_STATE_BIT = 0;
  localparam int SET_MODE_LSB = 1;
  localparam logic [2:0] MODE_AUTO = 3'h0;
  localparam logic [2:0] MODE_TRIG = 3'h1;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [31:0] STD_TRIG = 32'h0001_0000;
  localparam logic [47:0] STD_CHAN = 48'h0000_0032_ffce;
  localparam logic [SET_W-1:0] STD_SETTING = {STD_CHAN, STD_CHAN, STD_TRIG};
  localparam logic [9:0] SELFTEST_PASS = 10'h000;
endpackage

/* File: verification/ccs_store_assertions.sv */
/* Port checker for the common command and status store.
   Assumes it is bound onto ccs_store and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module ccs_assertions (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [3:0] CMD_CODE_IN,
  input wire logic [7:0] CMD_ARG_IN,
  input wire logic CMD_READY_OUT,
  input wire logic KEY_READY_OUT,
  input wire logic KEY_QUEUE_FLUSH_OUT,
  input wire logic EXEC_ERROR_OUT,
  input wire logic [9:0] RESP_DATA_OUT,
  input wire logic TRIGGER_FIRE_OUT,
  input wire logic [ccs_pkg::SET_W-1:0] ACTIVE_SETTING_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  // Code zero is no command, so c names only the command taken on this edge.
  wire logic [3:0] c = CMD_VALID_IN && CMD_READY_OUT ? CMD_CODE_IN : 4'h0;
  wire logic [7:0] a = CMD_ARG_IN;
  wire logic [2:0] md = ACTIVE_SETTING_OUT[3:1];
  wire logic st = ACTIVE_SETTING_OUT == ccs_pkg::STD_SETTING;
  wire logic bad = (c == ccs_pkg::CMD_RCL || c == ccs_pkg::CMD_SAV) && a > 8'h13;
  sequence s_blocked;
    !CMD_READY_OUT && !KEY_READY_OUT;
  endsequence
  a_test_blocks: assert property (c == ccs_pkg::CMD_TSTQ |=> s_blocked [*8])
    else $error("entry accepted during self-test");
  a_rst_flush: assert property (c == ccs_pkg::CMD_RST |=> KEY_QUEUE_FLUSH_OUT && st)
    else $error("reset command effect missing");
  a_recall_std: assert property (c == ccs_pkg::CMD_RCL && a == 8'h00 |=> st)
    else $error("slot zero not standard");
  a_bad_slot: assert property (bad |=> EXEC_ERROR_OUT && $stable(ACTIVE_SETTING_OUT))
    else $error("bad slot not refused");
  a_save_zero: assert property (
    c == ccs_pkg::CMD_SAV && a == 8'h00 |=> EXEC_ERROR_OUT)
    else $error("save to slot zero allowed");
  a_trig_fire: assert property (
    c == ccs_pkg::CMD_TRG && md == ccs_pkg::MODE_TRIG |=> TRIGGER_FIRE_OUT)
    else $error("trigger did not fire");
  a_wait_blocks: assert property (c == ccs_pkg::CMD_WAI |=> !CMD_READY_OUT [*8])
    else $error("command taken during wait");
  a_status_unused: assert property (
    c == ccs_pkg::CMD_STATUS_QUERY |=> RESP_DATA_OUT[9:7] == 3'h0 && RESP_DATA_OUT[3:1] == 3'h0)
    else $error("unused status bit set");
endmodule // ccs_assertions
bind ccs_store ccs_assertions chk_u (.*);
`default_nettype wire

/* File: verification/ccs_ctl_model.sv */
/* Bus controller model that issues common commands.
   Assumes ready is settled at falling clock edges. */
`timescale 1ns/10ps
`default_nettype none
module ccs_ctl_model (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out = 1'b0,
  output logic [3:0] code_out = 4'h0,
  output logic [7:0] arg_out = 8'h00,
  output logic timeout_out = 1'b0
);
  task automatic send(input logic [3:0] k, input logic [7:0] v = 8'h00, input int gap = 0);
    int n;
    n = 0;
    // An edge passes first, so valid never falls and rises in one time step.
    @(negedge clk_in);
    repeat (gap) @(negedge clk_in);
    while (ready_in !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    timeout_out = n == 200;
    valid_out = 1'b1;
    code_out = k;
    arg_out = v;
    @(posedge clk_in);
    @(negedge clk_in);
    // Released lines go inverse so a stale code is never read as a fresh one.
    valid_out = 1'b0;
    code_out = ~k;
    arg_out = ~v;
  endtask
endmodule // ccs_ctl_model
`default_nettype wire

/* File: verification/common_command_status_store_tb.sv */
/* Bench for the command store, driven through the controller model.
   Assumes shortened wait and self-test counts. */
`timescale 1ns/10ps
`default_nettype none
module common_command_status_store_tb;
  logic clk = 1'b0, rst_n = 1'b0, kv = 1'b0, we = 1'b0, mav = 1'b1;
  logic [7:0] eve = 8'h00;
  logic [127:0] sin = 128'h0;
  wire logic rdy, rv, tf, bf, vld, tmo, err, fl, oc, busy, kr;
  wire logic [3:0] cc;
  wire logic [7:0] ca;
  wire logic [9:0] rd;
  wire logic [127:0] act;
  int bad_count = 0, comparisons = 0, i;
  localparam logic [127:0] PAT = {4{32'h5a3c_0f96}};
  always #2 clk = ~clk;
  ccs_ctl_model ctl_u (.clk_in(clk), .ready_in(rdy), .valid_out(vld), .code_out(cc),
    .arg_out(ca), .timeout_out(tmo));
  ccs_store #(.WAIT_CYCLES(20), .SELFTEST_CYCLES(10)) dut_u (.CORE_CLK_IN(clk),
    .RESETN_IN(rst_n), .CMD_VALID_IN(vld), .CMD_CODE_IN(cc), .CMD_ARG_IN(ca),
    .CMD_READY_OUT(rdy), .KEY_VALID_IN(kv), .KEY_READY_OUT(kr), .KEY_QUEUE_FLUSH_OUT(fl),
    .OPC_CANCEL_OUT(oc), .EXEC_ERROR_OUT(err), .EVENT_STATUS_IN(8'h21), .EVENT_ENABLE_IN(eve),
    .MSG_AVAIL_IN(mav), .DEVICE_SUMMARY_IN(1'b1), .RESP_VALID_OUT(rv), .RESP_DATA_OUT(rd),
    .SELFTEST_RESULT_IN(10'h291), .SELFTEST_BUSY_OUT(busy), .TRIGGER_FIRE_OUT(tf),
    .BURST_FIRE_OUT(bf), .ACTIVE_SETTING_OUT(act), .SETTING_WE_IN(we), .SETTING_IN(sin));
  task automatic chk(input string n, input logic [127:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic load(input logic [127:0] v);
    sin = v;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge tmo) begin
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk("std", act, ccs_pkg::STD_SETTING);
    ctl_u.send(ccs_pkg::CMD_MASK_QUERY);
    chk("mask", 128'(rd), 128'h0);
    ctl_u.send(ccs_pkg::CMD_MASK_SET, 8'ha5);
    ctl_u.send(ccs_pkg::CMD_MASK_QUERY);
    chk("mask", 128'(rd), 128'ha5);
    for (i = 0; i < 3; i++) begin
      eve = 8'(i > 0);
      mav = i < 2;
      ctl_u.send(ccs_pkg::CMD_STATUS_QUERY);
      chk("status", 128'(rd), i > 1 ? 128'h61 : i > 0 ? 128'h71 : 128'h51);
    end
    mav = 1'b1;
    $display("test status done");
    load(PAT);
    ctl_u.send(ccs_pkg::CMD_SAV, 8'h13);
    ctl_u.send(ccs_pkg::CMD_RST);
    chk("rst", act, ccs_pkg::STD_SETTING);
    chk("flush", 128'({fl, oc}), 128'h3);
    ctl_u.send(ccs_pkg::CMD_MASK_QUERY);
    chk("mask", 128'(rd), 128'ha5);
    ctl_u.send(ccs_pkg::CMD_RCL, 8'h13, 3);
    chk("rcl", act, PAT);
    chk("okerr", 128'(err), 128'h0);
    ctl_u.send(ccs_pkg::CMD_SAV, 8'h00);
    chk("sav0err", 128'(err), 128'h1);
    ctl_u.send(ccs_pkg::CMD_RCL, 8'h14);
    chk("rclerr", 128'(err), 128'h1);
    chk("bad", act, PAT);
    ctl_u.send(ccs_pkg::CMD_RCL, 8'h00);
    chk("rcl0", act, ccs_pkg::STD_SETTING);
    $display("test store done");
    for (i = 0; i < 2; i++) begin
      load({ccs_pkg::STD_CHAN, ccs_pkg::STD_CHAN, 32'h0001_0003 + 32'(i * 4)});
      ctl_u.send(ccs_pkg::CMD_TRG);
      chk("fire", 128'({tf, bf}), i > 0 ? 128'h1 : 128'h2);
      chk("ext", 128'(act[0]), 128'h0);
    end
    $display("test trigger done");
    load(PAT);
    ctl_u.send(ccs_pkg::CMD_TSTQ);
    chk("busy", 128'({busy, kr, rdy}), 128'h4);
    sin = ~PAT;
    we = 1'b1;
    kv = 1'b1;
    for (i = 0; i < 50 && rv !== 1'b1; i++) begin
      @(negedge clk);
      we = i < 5;
    end
    kv = 1'b0;
    if (i == 50) begin
      bad_count++;
      complete_run();
    end
    chk("tst", 128'(rd), 128'h291);
    chk("restore", act, PAT);
    $display("test selftest done");
    ctl_u.send(ccs_pkg::CMD_WAI);
    chk("wait", 128'(rdy), 128'h0);
    ctl_u.send(ccs_pkg::CMD_MASK_SET, 8'h00);
    ctl_u.send(ccs_pkg::CMD_STATUS_QUERY);
    chk("status", 128'(rd), 128'h31);
    $display("test wait done");
    complete_run();
  end
endmodule // common_command_status_store_tb
`default_nettype wire
